// ==== ebwbr_pkg.sv ====
// shared constants, encodings and types for the external bus master
// assumes one 40 MHz clock; no software-visible registers
package ebwbr_pkg;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int OPND_W = 128;
  localparam int BEAT_W = 5;

  // transfer_size encodings; port widths reuse the same codes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  // read/write line levels
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ  = 1'b1;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA} ebwbr_state_t;

  // bytes carried by a size code
  function automatic logic [4:0] size_bytes(input logic [1:0] code);
    case (code)
      SZ_BYTE: size_bytes = 5'h01;
      SZ_WORD: size_bytes = 5'h02;
      SZ_LONG: size_bytes = 5'h04;
      default: size_bytes = 5'h10;
    endcase
  endfunction : size_bytes
endpackage : ebwbr_pkg

// ==== ebwbr_plan_if.sv ====
// planning signals between the bus sequencer and the beat planner
// assumes size codes of ebwbr_pkg for operand and port
`timescale 1ns/1ps
interface ebwbr_plan_if;
  logic [1:0] op_size;
  logic [1:0] port_size;
  logic       burst_en;
  logic       dram;
  logic [4:0] beats;
  logic [1:0] bus_size;
  logic [1:0] lane_size;
  logic [4:0] step;
  logic       burst;

  modport planner (input op_size, port_size, burst_en, dram,
                   output beats, bus_size, lane_size, step, burst);
  modport user    (output op_size, port_size, burst_en, dram,
                   input beats, bus_size, lane_size, step, burst);
endinterface : ebwbr_plan_if

// ==== ebwbr_planner.sv ====
// beat planner: burst decision, beat count, size code and address step
// assumes power-of-two operand and port widths
`timescale 1ns/1ps
module ebwbr_planner (
  ebwbr_plan_if.planner p
);
  logic [4:0] op_bytes;
  logic [4:0] port_bytes;
  logic       wide;

  // operand wider than port needs several beats
  always_comb begin
    op_bytes    = ebwbr_pkg::size_bytes(p.op_size);
    port_bytes  = ebwbr_pkg::size_bytes(p.port_size);
    wide        = op_bytes > port_bytes;
    p.burst     = wide && (p.burst_en || p.dram);
    p.beats     = wide ? 5'(op_bytes / port_bytes) : 5'h01;
    p.lane_size = wide ? p.port_size : p.op_size;
    p.step      = wide ? port_bytes : op_bytes;
    // bursts show operand size, inhibited beats show port size
    p.bus_size  = (wide && !p.burst) ? p.port_size : p.op_size;
  end
endmodule : ebwbr_planner

// ==== ebwbr_lane_mux.sv ====
// write lane replication: narrow data copied onto every lane
// assumes the beat's data sits left-aligned in chunk_in
`timescale 1ns/1ps
module ebwbr_lane_mux (
  input  wire logic [1:0]  lane_size_in,
  input  wire logic [31:0] chunk_in,
  output logic      [31:0] lanes_out
);
  // copies satisfy every address offset and upper-lane ports alike
  always_comb begin
    case (lane_size_in)
      ebwbr_pkg::SZ_BYTE: lanes_out = {4{chunk_in[31:24]}};
      ebwbr_pkg::SZ_WORD: lanes_out = {2{chunk_in[31:16]}};
      default:            lanes_out = chunk_in;
    endcase
  end
endmodule : ebwbr_lane_mux

// ==== ebwbr_master.sv ====
// external bus master: single and bursted transfers to 8/16/32-bit ports
// assumes synchronous pins, one clock, slave paces beats with transfer_ack_n
`timescale 1ns/1ps
// Operation
// - write bytes copied onto every lane by size
// - first clock: address, types, start strobe
// - write keeps rw low, size shows operand, or port size on inhibited beats
// - second clock: drop start, show privilege
// - write data held until acknowledge seen
// - acknowledge sampled from second clock; waits otherwise
// - burst when operand exceeds port and enabled
// - burst size lines show operand size
// - burst disabled regions get separate cycles
// - dram always bursts when operand exceeds port
// - line: four longwords, low address wraps
// - longword: two low bits step
// - word: lowest bit steps on narrow port
// - bursts have two to sixteen beats
// - 8, 16, 32-bit ports supported
// - narrow reads latch lanes per acknowledge
// - data released the clock after last beat
module ebwbr_master (
  input  wire logic         core_clk_in,
  input  wire logic         resetn_in,
  input  wire logic         req_valid_in,
  input  wire logic         req_write_in,
  input  wire logic [27:0]  req_addr_in,
  input  wire logic [1:0]   req_size_in,
  input  wire logic [1:0]   req_port_in,
  input  wire logic         req_burst_en_in,
  input  wire logic         req_dram_in,
  input  wire logic         req_super_in,
  input  wire logic         req_code_in,
  input  wire logic [1:0]   req_ttype_in,
  input  wire logic [127:0] req_wdata_in,
  output logic              req_ready_out,
  output logic              done_out,
  output logic [127:0]      rdata_out,
  output logic [27:0]       bus_addr_out,
  output logic [1:0]        transfer_size_out,
  output logic [1:0]        transfer_type_out,
  output logic              access_type_mode_out,
  output logic              bus_rw_out,
  output logic              transfer_start_n_out,
  output logic [31:0]       bus_data_out,
  output logic              bus_data_oe_out,
  input  wire logic [31:0]  bus_data_in,
  input  wire logic         transfer_ack_n_in
);
  ebwbr_plan_if plan ();

  ebwbr_pkg::ebwbr_state_t state_r, state_nxt;
  logic [27:0]  addr_r, addr_nxt;
  logic [1:0]   size_r, size_nxt;
  logic [1:0]   tt_r, tt_nxt;
  logic         rw_r, rw_nxt;
  logic         atm_r, atm_nxt;
  logic         ts_n_r, ts_n_nxt;
  logic [31:0]  dout_r, dout_nxt;
  logic         doe_r, doe_nxt;
  logic [1:0]   op_r, op_nxt;
  logic [1:0]   port_r, port_nxt;
  logic         ben_r, ben_nxt;
  logic         dram_r, dram_nxt;
  logic         super_r, super_nxt;
  logic         code_r, code_nxt;
  logic [4:0]   beat_r, beat_nxt;
  logic [4:0]   beats_r, beats_nxt;
  logic         burst_r, burst_nxt;
  logic [1:0]   lane_r, lane_nxt;
  logic [4:0]   step_r, step_nxt;
  logic         done_r, done_nxt;
  logic [127:0] rdata_r, rdata_nxt;
  logic [127:0] shift_r, shift_nxt;
  logic [127:0] rbuf_r, rbuf_nxt;
  logic [31:0]  lanes_w;
  logic [31:0]  rd_aligned;
  logic [1:0]   rd_ofs;
  logic [27:0]  wrap_mask;
  logic         accept;
  logic         ack_take;
  logic         last_beat;

  // planner sees the live request while idle, the held one after
  assign plan.op_size   = (state_r == ebwbr_pkg::ST_IDLE) ? req_size_in : op_r;
  assign plan.port_size = (state_r == ebwbr_pkg::ST_IDLE) ? req_port_in : port_r;
  assign plan.burst_en  = (state_r == ebwbr_pkg::ST_IDLE) ? req_burst_en_in : ben_r;
  assign plan.dram      = (state_r == ebwbr_pkg::ST_IDLE) ? req_dram_in : dram_r;

  ebwbr_planner u_planner (
    .p (plan.planner)
  );

  ebwbr_lane_mux u_lane_mux (
    .lane_size_in (lane_nxt),
    .chunk_in     (shift_nxt[127:96]),
    .lanes_out    (lanes_w)
  );

  // handshake terms
  assign accept    = (state_r == ebwbr_pkg::ST_IDLE) && req_valid_in;
  assign ack_take  = (state_r == ebwbr_pkg::ST_DATA) && !transfer_ack_n_in;
  assign last_beat = (beat_r == beats_r - 5'h01);
  assign wrap_mask = {23'h0, ebwbr_pkg::size_bytes(op_r) - 5'h01};

  // a narrow read sits on the lanes picked by the address within the port;
  // an 8-bit port always answers on the top lane, a 16-bit one on the upper half
  assign rd_ofs     = (port_r == ebwbr_pkg::SZ_LONG) ? addr_r[1:0] :
                      (port_r == ebwbr_pkg::SZ_WORD) ? {1'b0, addr_r[0]} : 2'h0;
  assign rd_aligned = bus_data_in << {rd_ofs, 3'h0};

  // operand shifters: write data leaves from the top, read data enters at the bottom
  always_comb begin
    shift_nxt = shift_r;
    rbuf_nxt  = rbuf_r;
    if (accept) begin
      rbuf_nxt = 128'h0;
      case (req_size_in)
        ebwbr_pkg::SZ_BYTE: shift_nxt = {req_wdata_in[7:0], 120'h0};
        ebwbr_pkg::SZ_WORD: shift_nxt = {req_wdata_in[15:0], 112'h0};
        ebwbr_pkg::SZ_LONG: shift_nxt = {req_wdata_in[31:0], 96'h0};
        default:            shift_nxt = req_wdata_in;
      endcase
    end else if (ack_take) begin
      case (lane_r)
        ebwbr_pkg::SZ_BYTE: begin
          shift_nxt = {shift_r[119:0], 8'h0};
          rbuf_nxt  = {rbuf_r[119:0], rd_aligned[31:24]};
        end
        ebwbr_pkg::SZ_WORD: begin
          shift_nxt = {shift_r[111:0], 16'h0};
          rbuf_nxt  = {rbuf_r[111:0], rd_aligned[31:16]};
        end
        default: begin
          shift_nxt = {shift_r[95:0], 32'h0};
          rbuf_nxt  = {rbuf_r[95:0], rd_aligned};
        end
      endcase
    end
  end

  // bus sequencer: start clock, data clocks with waits, next beat
  always_comb begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    size_nxt  = size_r;
    tt_nxt    = tt_r;
    rw_nxt    = rw_r;
    atm_nxt   = atm_r;
    ts_n_nxt  = ts_n_r;
    doe_nxt   = doe_r;
    op_nxt    = op_r;
    port_nxt  = port_r;
    ben_nxt   = ben_r;
    dram_nxt  = dram_r;
    super_nxt = super_r;
    code_nxt  = code_r;
    beat_nxt  = beat_r;
    beats_nxt = beats_r;
    burst_nxt = burst_r;
    lane_nxt  = lane_r;
    step_nxt  = step_r;
    rdata_nxt = rdata_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      ebwbr_pkg::ST_IDLE: begin
        if (accept) begin
          state_nxt = ebwbr_pkg::ST_START;
          addr_nxt  = req_addr_in;
          tt_nxt    = req_ttype_in;
          atm_nxt   = req_code_in;
          ts_n_nxt  = 1'b0;
          rw_nxt    = req_write_in ? ebwbr_pkg::RW_WRITE : ebwbr_pkg::RW_READ;
          size_nxt  = plan.bus_size;
          op_nxt    = req_size_in;
          port_nxt  = req_port_in;
          ben_nxt   = req_burst_en_in;
          dram_nxt  = req_dram_in;
          super_nxt = req_super_in;
          code_nxt  = req_code_in;
          beat_nxt  = 5'h00;
          beats_nxt = plan.beats;
          burst_nxt = plan.burst;
          lane_nxt  = plan.lane_size;
          step_nxt  = plan.step;
        end
      end
      ebwbr_pkg::ST_START: begin
        state_nxt = ebwbr_pkg::ST_DATA;
        ts_n_nxt  = 1'b1;
        atm_nxt   = super_r;
        doe_nxt   = (rw_r == ebwbr_pkg::RW_WRITE);
      end
      ebwbr_pkg::ST_DATA: begin
        // without acknowledge everything holds: a wait state
        if (ack_take) begin
          if (last_beat) begin
            state_nxt = ebwbr_pkg::ST_IDLE;
            done_nxt  = 1'b1;
            doe_nxt   = 1'b0;
            rdata_nxt = rbuf_nxt;
          end else begin
            beat_nxt = beat_r + 5'h01;
            // step within the operand's aligned block, wrapping
            addr_nxt = (addr_r & ~wrap_mask) | ((addr_r + {23'h0, step_r}) & wrap_mask);
            if (!burst_r) begin
              // inhibited: each beat is a cycle of its own
              state_nxt = ebwbr_pkg::ST_START;
              ts_n_nxt  = 1'b0;
              atm_nxt   = code_r;
              doe_nxt   = 1'b0;
            end
          end
        end
      end
    endcase
    dout_nxt = (rw_nxt == ebwbr_pkg::RW_WRITE) ? lanes_w : dout_r;
  end

  // register stage
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ebwbr_pkg::ST_IDLE;
      addr_r  <= 28'h0;
      size_r  <= 2'h0;
      tt_r    <= 2'h0;
      rw_r    <= ebwbr_pkg::RW_READ;
      atm_r   <= 1'b0;
      ts_n_r  <= 1'b1;
      dout_r  <= 32'h0;
      doe_r   <= 1'b0;
      op_r    <= 2'h0;
      port_r  <= 2'h0;
      ben_r   <= 1'b0;
      dram_r  <= 1'b0;
      super_r <= 1'b0;
      code_r  <= 1'b0;
      beat_r  <= 5'h00;
      beats_r <= 5'h01;
      burst_r <= 1'b0;
      lane_r  <= 2'h0;
      step_r  <= 5'h04;
      done_r  <= 1'b0;
      rdata_r <= 128'h0;
      shift_r <= 128'h0;
      rbuf_r  <= 128'h0;
    end else begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
      size_r  <= size_nxt;
      tt_r    <= tt_nxt;
      rw_r    <= rw_nxt;
      atm_r   <= atm_nxt;
      ts_n_r  <= ts_n_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      op_r    <= op_nxt;
      port_r  <= port_nxt;
      ben_r   <= ben_nxt;
      dram_r  <= dram_nxt;
      super_r <= super_nxt;
      code_r  <= code_nxt;
      beat_r  <= beat_nxt;
      beats_r <= beats_nxt;
      burst_r <= burst_nxt;
      lane_r  <= lane_nxt;
      step_r  <= step_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
      shift_r <= shift_nxt;
      rbuf_r  <= rbuf_nxt;
    end
  end

  // pins come straight from flops; ready is a handshake term
  assign req_ready_out        = (state_r == ebwbr_pkg::ST_IDLE);
  assign done_out             = done_r;
  assign rdata_out            = rdata_r;
  assign bus_addr_out         = addr_r;
  assign transfer_size_out    = size_r;
  assign transfer_type_out    = tt_r;
  assign access_type_mode_out = atm_r;
  assign bus_rw_out           = rw_r;
  assign transfer_start_n_out = ts_n_r;
  assign bus_data_out         = dout_r;
  assign bus_data_oe_out      = doe_r;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_wait;
    (state_r == ebwbr_pkg::ST_DATA) && transfer_ack_n_in;
  endsequence
  sequence s_final_write;
    ack_take && last_beat && (rw_r == ebwbr_pkg::RW_WRITE);
  endsequence
  sequence s_start_clock;
    !transfer_start_n_out ##1 transfer_start_n_out;
  endsequence

  AST_START_AFTER_ACCEPT: assert property (accept |=> s_start_clock)
    else $error("start strobe not one clock after accept");
  AST_WRITE_RW_LOW: assert property ((accept && req_write_in) |=> (bus_rw_out == 1'b0) [*2])
    else $error("rw not low in write cycle");
  AST_PRIV_SECOND: assert property ((state_r == ebwbr_pkg::ST_START) |=> access_type_mode_out == super_r)
    else $error("privilege not shown in second clock");
  AST_DATA_HOLD: assert property ((s_wait and bus_data_oe_out) |=> bus_data_oe_out && $stable(bus_data_out))
    else $error("write data changed during wait");
  AST_DONE_ON_ACK: assert property (done_out |-> $past(!transfer_ack_n_in) && $past(state_r) == ebwbr_pkg::ST_DATA)
    else $error("transfer ended without acknowledge");
  AST_BURST_SIZE: assert property ((state_r != ebwbr_pkg::ST_IDLE && burst_r) |-> transfer_size_out == op_r)
    else $error("burst size lines not operand size");
  AST_INHIBIT_RESTART: assert property ((ack_take && !last_beat && !burst_r) |=> !transfer_start_n_out)
    else $error("inhibited beat missing start strobe");
  AST_LINE_STEP: assert property ((ack_take && !last_beat && op_r == ebwbr_pkg::SZ_LINE &&
                                   port_r == ebwbr_pkg::SZ_LONG) |=> bus_addr_out[3:2] ==
                                   2'($past(bus_addr_out[3:2]) + 2'h1))
    else $error("line beat address not stepped");
  AST_BEAT_RANGE: assert property ((accept && plan.burst) |=> beats_r >= 5'h02 && beats_r <= 5'h10)
    else $error("burst beat count out of range");
  AST_RELEASE: assert property (s_final_write |=> !bus_data_oe_out)
    else $error("data bus not released after last beat");
  AST_HOLD_WAIT: assert property (s_wait |=> $stable(bus_addr_out) && $stable(transfer_size_out) &&
                                  $stable(transfer_type_out) && $stable(bus_rw_out))
    else $error("address or controls moved during wait");
endmodule : ebwbr_master

// ==== ebwbr_slave_model.sv ====
// byte-addressed memory slave answering the external bus master
// assumes the bench supplies the port width and wait count of each request
`timescale 1ns/1ps
module ebwbr_slave_model (
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [1:0]  port_in,
  input  wire logic [1:0]  waits_in,
  input  wire logic [27:0] bus_addr_in,
  input  wire logic [1:0]  transfer_size_in,
  input  wire logic        bus_rw_in,
  input  wire logic        transfer_start_n_in,
  input  wire logic [31:0] wdata_in,
  output logic [31:0]      rdata_out,
  output logic             transfer_ack_n_out
);
  logic [7:0]  mem [256];
  logic [31:0] last_r;
  logic        busy_r;
  logic [4:0]  left_r;
  logic [1:0]  wait_r;
  int          pb;
  int          base;

  function automatic int nbytes(input logic [1:0] c);
    return (c == 2'h1) ? 1 : (c == 2'h2) ? 2 : (c == 2'h0) ? 4 : 16;
  endfunction : nbytes

  // distinct preset contents so a wrong address shows up in read data
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 7 + 3);
  end

  // lanes valid only while ack shown; otherwise inverse of last value
  always_comb begin
    pb = nbytes(port_in);
    base = int'(bus_addr_in[7:0]) & ~(pb - 1);
    rdata_out = ~last_r;
    if (busy_r && !transfer_ack_n_out) begin
      for (int j = 0; j < 4; j++)
        if (j < pb) rdata_out[31 - 8 * j -: 8] = mem[8'(base + j)];
    end
  end

  // beat pacing: one ack per beat after waits_in wait states
  always @(posedge core_clk_in or negedge resetn_in) begin : seq
    int p;
    int s;
    int off;
    p = nbytes(port_in);
    s = nbytes(transfer_size_in);
    off = int'(bus_addr_in[7:0]) & (p - 1);
    if (!resetn_in) begin
      busy_r <= 1'b0;
      transfer_ack_n_out <= 1'b1;
      last_r <= 32'h0;
    end else if (!transfer_start_n_in) begin
      busy_r <= 1'b1;
      left_r <= 5'((s > p) ? s / p : 1);
      wait_r <= waits_in;
      transfer_ack_n_out <= (waits_in != 2'h0);
    end else if (busy_r) begin
      last_r <= rdata_out;
      if (!transfer_ack_n_out) begin
        // write lanes captured only on the acknowledged edge
        if (bus_rw_in == 1'b0) begin
          for (int i = 0; i < ((s < p) ? s : p); i++)
            mem[8'(int'(bus_addr_in[7:0]) + i)] = wdata_in[31 - 8 * (off + i) -: 8];
        end
        left_r <= left_r - 5'h1;
        busy_r <= (left_r != 5'h1);
        wait_r <= waits_in;
        transfer_ack_n_out <= (left_r == 5'h1) || (waits_in != 2'h0);
      end else begin
        wait_r <= wait_r - 2'h1;
        transfer_ack_n_out <= (wait_r > 2'h1);
      end
    end
  end
endmodule : ebwbr_slave_model

// ==== external_bus_write_and_burst_read_test.sv ====
// self-checking bench: write then read back every size on every port width
// assumes the master and the memory slave model; one 40 MHz clock
`timescale 1ns/1ps
module external_bus_write_and_burst_read_test;
  typedef struct { logic rd; logic [127:0] data; } ebwbr_note_t;
  logic         clk, rstn, valid, wr, be, dram, sup, code, ready, done, access_type_mode, rw, start_n, oe, ack_n;
  logic [1:0]   sz, pt, tt, tsz, tto, waits;
  logic [27:0]  addr, baddr;
  logic [127:0] wdata, rdata;
  logic [31:0]  dout, din;
  logic [7:0]   shadow [256];
  ebwbr_note_t  notes[$];
  ebwbr_note_t  cmp_note;
  int           num_errors = 0;
  int           comparisons = 0;

  ebwbr_master ebwbr_master_inst (.core_clk_in(clk), .resetn_in(rstn), .req_valid_in(valid),
    .req_write_in(wr), .req_addr_in(addr), .req_size_in(sz), .req_port_in(pt), .req_burst_en_in(be),
    .req_dram_in(dram), .req_super_in(sup), .req_code_in(code), .req_ttype_in(tt),
    .req_wdata_in(wdata), .req_ready_out(ready), .done_out(done), .rdata_out(rdata),
    .bus_addr_out(baddr), .transfer_size_out(tsz), .transfer_type_out(tto),
    .access_type_mode_out(access_type_mode), .bus_rw_out(rw), .transfer_start_n_out(start_n),
    .bus_data_out(dout), .bus_data_oe_out(oe), .bus_data_in(din), .transfer_ack_n_in(ack_n));

  ebwbr_slave_model ebwbr_slave_model_inst (.core_clk_in(clk), .resetn_in(rstn), .port_in(pt),
    .waits_in(waits), .bus_addr_in(baddr), .transfer_size_in(tsz), .bus_rw_in(rw),
    .transfer_start_n_in(start_n), .wdata_in(dout), .rdata_out(din), .transfer_ack_n_out(ack_n));

  // 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic int nb(input logic [1:0] c);
    return (c == 2'h1) ? 1 : (c == 2'h2) ? 2 : (c == 2'h0) ? 4 : 16;
  endfunction : nb

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : check

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // one request: note the expected result, check the opening clocks, await done
  task automatic do_req(input logic w, input logic [1:0] s, input logic [1:0] p, input logic [27:0] a);
    int          n;
    int          idx;
    logic        bst;
    logic [1:0]  esz;
    ebwbr_note_t nt;
    // enables and data set by the caller at its last edge are settled only now
    @(posedge clk);
    n = nb(s);
    bst = (n > nb(p)) && (be || dram);
    esz = (bst || n <= nb(p)) ? s : p;
    nt.rd = !w;
    nt.data = '0;
    // operand bytes leave MSB first, wrapping inside the aligned block
    for (int k = 0; k < n; k++) begin
      idx = (int'(a[7:0]) & ~(n - 1)) | ((int'(a[7:0]) + k) & (n - 1));
      if (w)
        shadow[idx] = wdata[8 * (n - 1 - k) +: 8];
      nt.data[8 * (n - 1 - k) +: 8] = shadow[idx];
    end
    valid <= 1'b1;
    wr <= w;
    sz <= s;
    pt <= p;
    addr <= a;
    @(posedge clk);
    valid <= 1'b0;
    notes.push_back(nt);
    #1;
    check("start_n c1", 0, start_n);
    check("ready c1", 0, ready);
    check("addr c1", a, baddr);
    check("ttype c1", tt, tto);
    check("atm c1", code, access_type_mode);
    check("rw c1", !w, rw);
    check("size c1", esz, tsz);
    @(posedge clk) #1;
    check("start_n c2", 1, start_n);
    check("atm c2", sup, access_type_mode);
    for (int t = 0; t < 300 && done !== 1'b1; t++)
      @(posedge clk) #1;
    if (done !== 1'b1)
      check("done", 1, done);
  endtask : do_req

  // result watcher: oldest note against each completion
  always @(posedge clk) begin
    #2;
    if (done === 1'b1) begin
      if (notes.size() == 0)
        check("spare done", 1, 0);
      else begin
        cmp_note = notes.pop_front();
        if (cmp_note.rd)
          check("rdata", cmp_note.data, rdata);
        check("data_oe", 0, oe);
        check("ready", 1, ready);
      end
    end
  end

  // main sequence: every size on every port, random enables and waits
  initial begin : main
    int al;
    {valid, wr, be, dram, sup, code, sz, pt, tt, waits, addr, wdata} = '0;
    rstn = 1'b0;
    for (int i = 0; i < 256; i++)
      shadow[i] = 8'(i * 7 + 3);
    void'($urandom(32'hab16));
    repeat (12) @(posedge clk);
    check("reset start_n", 1, start_n);
    check("reset oe", 0, oe);
    rstn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 4; s++) begin
        for (int r = 0; r < 2; r++) begin
          al = (s == 3) ? 4 : nb(2'(s));
          @(posedge clk);
          {be, dram, sup, code, tt} <= 6'($urandom());
          waits <= 2'($urandom_range(2));
          wdata <= {$urandom(), $urandom(), $urandom(), $urandom()};
          do_req(1'b1, 2'(s), 2'(p), 28'($urandom_range(255)) & ~28'(al - 1));
          do_req(1'b0, 2'(s), 2'(p), addr);
        end
      end
    end
    repeat (3) @(posedge clk);
    check("notes left", 0, notes.size());
    stop_test();
  end

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : external_bus_write_and_burst_read_test
